// ===== dv/frs_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// floppy drive: head position, ready and fault lines
// ==========================================================
module frs_drive_model (
    input  wire logic       clk_i,    // system clock
    input  wire logic       rst_i,    // sync reset
    input  wire logic       step_i,   // step toward track zero
    input  wire logic       load_i,   // park head at park_i
    input  wire logic [7:0] park_i,   // park track
    input  wire logic       ready_i,  // medium in place
    input  wire logic       fault_i,  // fault to report
    output logic            ready_o,  // drive ready level
    output logic            track0_o, // head at track zero
    output logic            fault_o   // drive fault level
);
    logic [7:0] track_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || load_i)
            track_reg <= park_i;
        else if (step_i && track_reg != 8'h00)
            track_reg <= track_reg - 8'h01;
    end

    assign track0_o = (track_reg == 8'h00);
    assign ready_o  = ready_i;
    assign fault_o  = fault_i;
endmodule // frs_drive_model
`default_nettype wire

// ===== dv/test_frs_result_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_frs_result_status;
    import frs_pkg::*;
    logic clk_i, rst_i, start, rw, done, head, over, crc, step, rdy, flt, load;
    logic ack, err, cmd_rdy, drdy, trk0, dflt, wer, hs;
    logic [1:0] unit, us;
    logic [7:0] park;
    logic [31:0] rdat, q;
    frs_wb_req_s req;
    frs_status0_s status0;
    frs_st1_s st1;
    int miscompares, num_checks;

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    frs_result_status dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .cmd_start_i(start), .cmd_is_rw_i(rw),
        .cmd_done_i(done), .drive_ready_i(drdy), .head_sel_i(head), .unit_sel_i(unit),
        .sector_over_i(over), .crc_fail_i(crc), .drive_fault_i(dflt), .step_i(step),
        .track0_i(trk0), .status0_o(status0), .st1_o(st1), .cmd_ready_o(cmd_rdy));

    frs_drive_model drive (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .load_i(load),
        .park_i(park), .ready_i(rdy), .fault_i(flt), .ready_o(drdy), .track0_o(trk0),
        .fault_o(dflt));

    // ==========================================================
    // access and check tasks
    // ==========================================================
    task automatic wrap_up;
        $display("mismatches %0d, checks %0d", miscompares, num_checks);
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        req <= '{1'b1, 1'b1, w, 4'h1, a, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (!(ack || err) && n < 20);
        if (!(ack || err))
        begin
            miscompares++;
            wrap_up();
        end
        r = rdat;
        wer = err;
        req <= '0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask

    task automatic cmd(input logic w, input logic h, input logic [1:0] u);
        @(posedge clk_i);
        start <= 1'b1;
        rw <= w;
        head <= h;
        unit <= u;
        @(posedge clk_i);
        start <= 1'b0;
    endtask

    task automatic fin(input logic h, input logic [1:0] u);
        @(posedge clk_i);
        done <= 1'b1;
        head <= h;
        unit <= u;
        @(posedge clk_i);
        done <= 1'b0;
    endtask

    // one-cycle pulse of {over, crc, step}
    task automatic ev(input logic [2:0] e);
        @(posedge clk_i);
        {over, crc, step} <= e;
        @(posedge clk_i);
        {over, crc, step} <= 3'h0;
    endtask

    task automatic res(input logic [31:0] e0, input logic [31:0] e1);
        rd(FRS_OFS_STATUS0, e0);
        chk({31'h0, cmd_rdy}, 32'h0);
        chk({24'h0, status0}, e0);
        chk({24'h0, st1}, e1);
        rd(FRS_OFS_STATUS1, e1);
        chk({31'h0, cmd_rdy}, 32'h1);
    endtask

    function automatic logic [31:0] s0(input logic [1:0] tc, input logic ef, nrdy, h,
                                       input logic [1:0] u);
        return {24'h0, tc, 1'b0, ef, nrdy, h, u};
    endfunction

    // ==========================================================
    // scenarios
    // ==========================================================
    initial
    begin
        miscompares = 0;
        num_checks = 0;
        rst_i = 1'b1;
        req = '0;
        {start, rw, done, head, over, crc, step, flt, load} = '0;
        unit = 2'h0;
        rdy = 1'b1;
        park = 8'h05;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(FRS_OFS_STATUS0, 32'h0);
        rd(FRS_OFS_STATUS1, 32'h0);
        rd(FRS_OFS_CTRL, 32'hf);
        rd(4'hc, 32'h0);
        chk({31'h0, wer}, 32'h1);
        rdy <= 1'b0;
        cmd(1'b1, 1'b0, 2'h0);
        fin(1'b0, 2'h0);
        ev(3'h2);
        cmd(1'b0, 1'b0, 2'h0);
        res(s0(2'h0, 1'b0, 1'b1, 1'b0, 2'h0), 32'h0);
        cmd(1'b0, 1'b0, 2'h0);
        fin(1'b0, 2'h0);
        res(s0(2'h0, 1'b0, 1'b0, 1'b0, 2'h0), 32'h0);
        rdy <= 1'b1;
        wb(1'b1, FRS_OFS_CTRL, 32'hd, q);
        rd(FRS_OFS_CTRL, 32'hd);
        for (int i = 0; i < 3; i++)
        begin
            hs = (i != 1);
            us = (i == 2) ? 2'h2 : 2'h1;
            cmd(1'b1, hs, us);
            fin(hs, us);
            res(s0(2'h0, 1'b0, i == 0, hs, us), 32'h0);
        end
        for (int i = 0; i < 4; i++)
        begin
            hs = i[0];
            us = i[1:0];
            cmd(1'b0, ~hs, ~us);
            fin(hs, us);
            res(s0(2'h0, 1'b0, 1'b0, hs, us), 32'h0);
        end
        ev(3'h2);
        cmd(1'b1, 1'b0, 2'h0);
        ev(3'h4);
        fin(1'b0, 2'h0);
        res(32'h0, 32'h80);
        cmd(1'b0, 1'b0, 2'h0);
        ev(3'h2);
        ev(3'h6);
        fin(1'b0, 2'h0);
        res(32'h0, 32'ha0);
        cmd(1'b0, 1'b0, 2'h0);
        rdy <= 1'b0;
        @(posedge clk_i);
        rdy <= 1'b1;
        fin(1'b0, 2'h0);
        res(s0(2'h3, 1'b0, 1'b0, 1'b0, 2'h0), 32'h0);
        cmd(1'b0, 1'b0, 2'h0);
        flt <= 1'b1;
        @(posedge clk_i);
        flt <= 1'b0;
        fin(1'b0, 2'h0);
        res(s0(2'h0, 1'b1, 1'b0, 1'b0, 2'h0), 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            park <= (i < 2) ? 8'h64 : 8'h05;
            load <= 1'b1;
            @(posedge clk_i);
            load <= 1'b0;
            cmd(1'b0, 1'b0, 2'h0);
            repeat ((i == 0) ? 76 : 77) ev(3'h1);
            fin(1'b0, 2'h0);
            res(s0(2'h0, i == 1, 1'b0, 1'b0, 2'h0), 32'h0);
        end
        wrap_up();
    end
endmodule // test_frs_result_status
`default_nettype wire

// ===== src/frs_pkg.sv
package frs_pkg;

    // ==========================================================
    // register map (byte addresses, one 32-bit word each)
    // ==========================================================
    localparam logic [3:0] FRS_OFS_STATUS0 = 4'h0;
    localparam logic [3:0] FRS_OFS_STATUS1 = 4'h4;
    localparam logic [3:0] FRS_OFS_CTRL    = 4'h8;

    // ==========================================================
    // reset values and codes
    // ==========================================================
    localparam logic [3:0] FRS_CTRL_RST    = 4'hf;
    localparam logic [1:0] FRS_TC_NORMAL   = 2'h0;
    localparam logic [1:0] FRS_TC_RDY_CHG  = 2'h3;
    localparam int         FRS_STEP_LIMIT  = 77;

    // ==========================================================
    // result status bytes
    // ==========================================================
    typedef struct packed {
        logic [1:0] termination_code;
        logic       seek_end;
        logic       equipment_fault_flag;
        logic       drive_not_ready_flag;
        logic       head_side_flag;
        logic       unit_number_high_bit;
        logic       unit_number_low_bit;
    } frs_status0_s;

    typedef struct packed {
        logic       end_of_cylinder_flag;
        logic       unused_zero;
        logic       crc_error_flag;
        logic [4:0] other_flags;
    } frs_st1_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } frs_wb_req_s;

    typedef enum logic [2:0] {
        FRS_IDLE   = 3'b001,
        FRS_EXEC   = 3'b010,
        FRS_RESULT = 3'b100
    } frs_state_e;

endpackage

// ===== src/frs_result_status.sv
`timescale 1ns/1ps
`default_nettype none
module frs_result_status (
    input  wire logic               clk_i,          // system clock, 10 MHz
    input  wire logic               rst_i,          // sync reset, active high
    input  wire frs_pkg::frs_wb_req_s wb_req_i,     // wishbone request group
    output logic [31:0]             wb_dat_o,       // wishbone read data
    output logic                    wb_ack_o,       // wishbone ack
    output logic                    wb_err_o,       // unmapped access
    input  wire logic               cmd_start_i,    // command begins (pulse)
    input  wire logic               cmd_is_rw_i,    // command is read or write
    input  wire logic               cmd_done_i,     // command ends, interrupt
    input  wire logic               drive_ready_i,  // drive ready level
    input  wire logic               head_sel_i,     // selected head side
    input  wire logic [1:0]         unit_sel_i,     // selected drive unit
    input  wire logic               sector_over_i,  // sector past cylinder end
    input  wire logic               crc_fail_i,     // ID or data CRC failed
    input  wire logic               drive_fault_i,  // drive fault level
    input  wire logic               step_i,         // recalibrate step pulse
    input  wire logic               track0_i,       // track zero level
    output frs_pkg::frs_status0_s   status0_o,      // status byte 0
    output frs_pkg::frs_st1_s       st1_o,          // status byte 1
    output logic                    cmd_ready_o     // may take a command
);
    import frs_pkg::*;

    // ==========================================================
    // state and storage
    // ==========================================================
    frs_state_e   state_reg;
    frs_state_e   state_next;
    frs_status0_s status0_reg;
    frs_status0_s status0_next;
    frs_st1_s     st1_reg;
    frs_st1_s     st1_next;
    logic [3:0]   ctrl_reg;
    logic         rdy_prev_reg;
    logic         ack_reg;
    logic         err_reg;
    logic [31:0]  dat_reg;
    logic         step_missing;

    // ==========================================================
    // decode
    // ==========================================================
    wire in_idle  = (state_reg == FRS_IDLE);
    wire in_exec  = (state_reg == FRS_EXEC);
    wire in_res   = (state_reg == FRS_RESULT);
    wire start    = in_idle && cmd_start_i;
    wire req      = wb_req_i.cyc && wb_req_i.stb && !ack_reg && !err_reg;
    wire hit_s0   = (wb_req_i.adr == FRS_OFS_STATUS0);
    wire hit_s1   = (wb_req_i.adr == FRS_OFS_STATUS1);
    wire hit_ctl  = (wb_req_i.adr == FRS_OFS_CTRL);
    wire mapped   = hit_s0 || hit_s1 || hit_ctl;
    wire wr_ctl   = req && wb_req_i.we && hit_ctl && wb_req_i.sel[0];
    wire rd_s1    = req && !wb_req_i.we && hit_s1;
    wire two_side = ctrl_reg[unit_sel_i];
    wire unready  = cmd_is_rw_i && (!drive_ready_i
                    || (head_sel_i && !two_side));
    wire rdy_chg  = in_exec && (drive_ready_i != rdy_prev_reg);
    wire faulted  = in_exec && (drive_fault_i || step_missing);
    wire [31:0] rd_mux = hit_s0 ? {24'h000000, status0_reg} :
                         hit_s1 ? {24'h000000, st1_reg} :
                                  {28'h0000000, ctrl_reg};

    assign state_next = start                   ? FRS_EXEC   :
                        (in_exec && cmd_done_i) ? FRS_RESULT :
                        (in_res && rd_s1)       ? FRS_IDLE   : state_reg;

    frs_step_watch #(
        .LIMIT     (FRS_STEP_LIMIT)
    ) u_step (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clear_i   (start),
        .step_i    (step_i && in_exec),
        .track0_i  (track0_i),
        .missing_o (step_missing)
    );

    // ==========================================================
    // next status values; sets override the start clear
    // ==========================================================
    always_comb
    begin
        status0_next = status0_reg;
        st1_next = st1_reg;
        if (start)
        begin
            status0_next = '0;
            st1_next = '0;
            status0_next.drive_not_ready_flag = unready;
        end
        if (rdy_chg)
            status0_next.termination_code = FRS_TC_RDY_CHG;
        if (faulted)
            status0_next.equipment_fault_flag = 1'b1;
        if (in_exec && sector_over_i)
            st1_next.end_of_cylinder_flag = 1'b1;
        if (in_exec && crc_fail_i)
            st1_next.crc_error_flag = 1'b1;
        if (in_exec && cmd_done_i)
        begin
            status0_next.head_side_flag = head_sel_i;
            {status0_next.unit_number_high_bit,
             status0_next.unit_number_low_bit} = unit_sel_i;
        end
        st1_next.unused_zero = 1'b0;
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg    <= FRS_IDLE;
            status0_reg  <= '0;
            st1_reg      <= '0;
            rdy_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            status0_reg  <= status0_next;
            st1_reg      <= st1_next;
            rdy_prev_reg <= drive_ready_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= FRS_CTRL_RST;
            ack_reg  <= 1'b0;
            err_reg  <= 1'b0;
            dat_reg  <= 32'h00000000;
        end
        else
        begin
            if (wr_ctl)
                ctrl_reg <= wb_req_i.dat[3:0];
            ack_reg <= req && mapped;
            err_reg <= req && !mapped;
            // unmapped reads return zero rather than stale data
            if (req && !wb_req_i.we)
                dat_reg <= mapped ? rd_mux : 32'h00000000;
        end
    end

    assign wb_ack_o    = ack_reg;
    assign wb_err_o    = err_reg;
    assign wb_dat_o    = dat_reg;
    assign status0_o   = status0_reg;
    assign st1_o       = st1_reg;
    assign cmd_ready_o = in_idle;

    // ==========================================================
    // checks
    // ==========================================================
    sequence s_done;
        in_exec && cmd_done_i;
    endsequence

    sequence s_hold;
        in_res && !rd_s1;
    endsequence

    unready_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start && cmd_is_rw_i && !drive_ready_i |=> status0_reg.drive_not_ready_flag)
        else $error("not-ready flag missing for unready drive");

    single_side_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start && cmd_is_rw_i && head_sel_i && !ctrl_reg[unit_sel_i]
        |=> status0_reg.drive_not_ready_flag)
        else $error("not-ready flag missing for side 1 on single side");

    head_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_done |=> status0_reg.head_side_flag == $past(head_sel_i))
        else $error("head flag differs from head at end");

    unit_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_done |=> status0_reg[1:0] == $past(unit_sel_i))
        else $error("unit bits differ from unit at end");

    eoc_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_exec && sector_over_i |=> st1_reg.end_of_cylinder_flag [*1] ##1 1)
        else $error("end-of-cylinder flag not set");

    bit6_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_reg && $past(hit_s1 && !wb_req_i.we) |-> wb_dat_o[6] == 1'b0)
        else $error("bit 6 of status byte 1 read as one");

    crc_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_exec && crc_fail_i |=> st1_reg.crc_error_flag)
        else $error("crc flag not set");

    rdy_chg_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_exec && $changed(drive_ready_i) && !$past(start)
        |=> status0_reg.termination_code == FRS_TC_RDY_CHG)
        else $error("ready change not reported");

    fault_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_exec && drive_fault_i |=> status0_reg.equipment_fault_flag)
        else $error("equipment fault flag not set");

    hold_res_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_hold |=> $stable(status0_reg) && $stable(st1_reg))
        else $error("status changed before host read");

endmodule // frs_result_status
`default_nettype wire

// ===== src/frs_step_watch.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// recalibrate step watchdog
// ==========================================================
module frs_step_watch #(
    parameter int LIMIT = frs_pkg::FRS_STEP_LIMIT
) (
    input  wire logic clk_i,      // system clock
    input  wire logic rst_i,      // sync reset, active high
    input  wire logic clear_i,    // new command starts
    input  wire logic step_i,     // one step pulse issued
    input  wire logic track0_i,   // head at track zero
    output logic      missing_o   // limit reached, no track zero
);
    import frs_pkg::*;

    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    wire        at_limit = (cnt_reg == 7'(LIMIT));

    assign cnt_next  = clear_i ? 7'h00 :
                       (step_i && !at_limit) ? cnt_reg + 7'h01 : cnt_reg;
    assign missing_o = at_limit && !track0_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_reg <= 7'h00;
        else
            cnt_reg <= cnt_next;
    end

    step_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cnt_reg <= 7'(LIMIT))
        else $error("step count passed its limit");

endmodule // frs_step_watch
`default_nettype wire
